// ==== accc_pkg.sv ====
package accc_pkg;
    // Core and bank structure
    localparam int NUM_CORES      = 3;
    localparam int BANKS_PER_CORE = 2;
    localparam int NUM_BANKS      = NUM_CORES * BANKS_PER_CORE;
    localparam int SAMPLE_W       = 12;
    localparam logic [11:0] MID_CODE = 12'h000;

    // Core indices
    localparam logic [1:0] CORE_A = 2'h0;
    localparam logic [1:0] CORE_B = 2'h1;
    localparam logic [1:0] CORE_C = 2'h2;

    // Register map (word offsets on the plain port)
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CFG    = 4'h0;
    localparam logic [3:0] REG_TRIG   = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_TRIM0  = 4'h3;

    // Configuration bit positions
    localparam int CFG_BG     = 0;
    localparam int CFG_SRCSEL = 1;
    localparam int CFG_FGOS   = 2;
    localparam int CFG_BGOS   = 3;
    localparam int CFG_DUAL   = 4;
    localparam int CFG_INSEL  = 5;
    localparam logic [7:0] CFG_RESET = 8'h10;

    // Status bit positions
    localparam int ST_FG_DONE = 0;
    localparam int ST_BUSY    = 1;

    // Trim registers: offset, gain, interleave timing, termination
    localparam int NUM_TRIM = 4;
    localparam int TRIM_W   = 8;

    // Calibration timing
    localparam int CLK_MHZ         = 50;
    localparam int BANK_CAL_US     = 2;
    localparam int BANK_CAL_CYCLES = BANK_CAL_US * CLK_MHZ;
    localparam int STEPS_PER_BANK  = 3;

    typedef enum logic [1:0] {
        ACCC_STEP_LIN,
        ACCC_STEP_GAIN,
        ACCC_STEP_OFS
    } accc_step_t;
endpackage

// ==== accc_cal_engine.sv ====
`timescale 1ns/1ns
// Walks one core's two banks through linearity, gain and offset steps
module accc_cal_engine #(
    parameter int STEP_CYCLES = accc_pkg::BANK_CAL_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    output logic             busy,
    output logic             done,
    output logic             stim_en,
    output logic [1:0]       step,
    output logic             bank
);
    localparam int CW         = $clog2(STEP_CYCLES + 1);
    localparam int RUN_CYCLES = accc_pkg::BANKS_PER_CORE * accc_pkg::STEPS_PER_BANK
                                * STEP_CYCLES;
    localparam int RW         = $clog2(RUN_CYCLES + 1);

    initial begin
        if (STEP_CYCLES < 1) begin
            $error("STEP_CYCLES must be at least one");
        end
    end

    logic [CW-1:0]        cnt_ff;
    accc_pkg::accc_step_t step_ff;
    logic                 bank_ff;
    logic                 busy_ff;
    logic                 done_ff;
    logic [RW-1:0]        run_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= '0;
            step_ff <= accc_pkg::ACCC_STEP_LIN;
            bank_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff) begin
                if (start) begin
                    busy_ff <= 1'b1;
                    cnt_ff  <= '0;
                    step_ff <= accc_pkg::ACCC_STEP_LIN;
                    bank_ff <= 1'b0;
                end
            end else if (cnt_ff != CW'(STEP_CYCLES - 1)) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else begin
                cnt_ff <= '0;
                case (step_ff)
                    accc_pkg::ACCC_STEP_LIN:  step_ff <= accc_pkg::ACCC_STEP_GAIN;
                    accc_pkg::ACCC_STEP_GAIN: step_ff <= accc_pkg::ACCC_STEP_OFS;
                    accc_pkg::ACCC_STEP_OFS: begin
                        step_ff <= accc_pkg::ACCC_STEP_LIN;
                        if (bank_ff) begin
                            busy_ff <= 1'b0;
                            done_ff <= 1'b1;
                        end
                        bank_ff <= ~bank_ff;
                    end
                    default: step_ff <= accc_pkg::ACCC_STEP_LIN;
                endcase
            end
        end
    end

    assign busy    = busy_ff;
    assign done    = done_ff;
    assign stim_en = busy_ff;
    assign step    = step_ff;
    assign bank    = bank_ff;

    // Run length is exact: 2 banks x 3 steps x STEP_CYCLES
    // busy span counter, read only by the check
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            run_ff <= '0;
        end else if (!busy_ff) begin
            run_ff <= '0;
        end else begin
            run_ff <= run_ff + 1'b1;
        end
    end

    sequence_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(busy_ff) |-> busy_ff [*2] ##0 !done_ff)
        else $error("calibration ended too early");
    run_len_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        done_ff |-> run_ff == RW'(RUN_CYCLES))
        else $error("calibration run length wrong");
endmodule

// ==== accc_top.sv ====
`timescale 1ns/1ns
// How it works
// - Foreground or background mode, by configuration
// - Foreground: cores offline, output mid-code
// - Background keeps converting, core substituted
// - Six banks paired into three cores
// - Banks in a core sample opposite phases
// - Dual: A takes input_a, B input_b
// - Spare core C replaces A or B
// - Calibrate linearity, gain, offset per bank
// - Trims load defaults, readable and writable
// - Foreground calibration runs after power-up
// - Trigger from pin or software bit
// - Calibrated spare takes over, rotation repeats
module accc_top #(
    parameter int STEP_CYCLES = accc_pkg::BANK_CAL_CYCLES,
    parameter logic [31:0] TRIM_DEFAULTS = 32'h80808080
) (
    input  wire logic                   ref_clk,
    input  wire logic                   arst_n,
    input  wire logic                   cal_trigger_pin,
    input  wire logic [11:0]            input_a,
    input  wire logic [11:0]            input_b,
    input  wire logic [3:0]             addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic      [7:0]             rdata,
    output logic      [11:0]            sample_out0,
    output logic      [11:0]            sample_out1,
    output logic      [2:0]             core_online,
    output logic      [5:0]             bank_phase,
    output logic                        fg_done,
    output logic                        cal_busy
);
    initial begin
        if (accc_pkg::NUM_BANKS != 6 || accc_pkg::NUM_CORES != 3 || accc_pkg::NUM_TRIM != 4) begin
            $error("block serves three cores of two banks only");
        end
    end

    typedef enum logic [2:0] {
        ACCC_ST_IDLE,
        ACCC_ST_FG_RUN,
        ACCC_ST_BG_CAL,
        ACCC_ST_BG_SWAP
    } accc_state_t;

    function automatic logic [1:0] accc_next_core(input logic [1:0] c);
        accc_next_core = (c == accc_pkg::CORE_C) ? accc_pkg::CORE_A : c + 2'h1;
    endfunction

    function automatic logic accc_is_trim(input logic [3:0] a);
        accc_is_trim = a >= accc_pkg::REG_TRIM0
                       && a < accc_pkg::REG_TRIM0 + 4'(accc_pkg::NUM_TRIM);
    endfunction

    function automatic logic [1:0] accc_trim_idx(input logic [3:0] a);
        accc_trim_idx = 2'(a - accc_pkg::REG_TRIM0);
    endfunction

    accc_state_t  state_ff;
    logic [7:0]   cfg_ff;
    logic         soft_trig_ff;
    logic         trig_d_ff;
    logic         fg_done_ff;
    logic         pwr_cal_ff;
    logic         cal_busy_ff;
    logic [7:0]   trim_ff [accc_pkg::NUM_TRIM];
    logic [1:0]   spare_ff;
    logic [1:0]   slot_a_ff;
    logic [1:0]   slot_b_ff;
    logic [7:0]   rdata_ff;
    logic [11:0]  out0_ff;
    logic [11:0]  out1_ff;
    logic [2:0]   online_ff;
    logic [5:0]   phase_ff;
    logic         eng_start_ff;
    logic         eng_busy;
    logic         eng_done;
    logic         trig_sel;
    logic         trig_rise;

    accc_cal_engine #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_engine (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .start   (eng_start_ff),
        .busy    (eng_busy),
        .done    (eng_done),
        .stim_en (),
        .step    (),
        .bank    ()
    );

    assign trig_sel  = cfg_ff[accc_pkg::CFG_SRCSEL] ? cal_trigger_pin : soft_trig_ff;
    assign trig_rise = trig_sel && !trig_d_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_d_ff <= 1'b0;
        end else begin
            trig_d_ff <= trig_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < accc_pkg::NUM_TRIM; i++) begin
                trim_ff[i] <= TRIM_DEFAULTS[i*8 +: 8];
            end
        end else if (wr_en && accc_is_trim(addr)) begin
            trim_ff[accc_trim_idx(addr)] <= wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff       <= accc_pkg::CFG_RESET;
            soft_trig_ff <= 1'b0;
        end else if (wr_en) begin
            if (addr == accc_pkg::REG_CFG) begin
                cfg_ff <= wdata;
            end
            if (addr == accc_pkg::REG_TRIG) begin
                soft_trig_ff <= wdata[0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                accc_pkg::REG_CFG:    rdata_ff <= cfg_ff;
                accc_pkg::REG_TRIG:   rdata_ff <= {7'h00, soft_trig_ff};
                accc_pkg::REG_STATUS: rdata_ff <= {6'h00, eng_busy, fg_done_ff};
                default: begin
                    rdata_ff <= accc_is_trim(addr) ? trim_ff[accc_trim_idx(addr)] : 8'h00;
                end
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // Calibration sequencer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= ACCC_ST_IDLE;
            pwr_cal_ff   <= 1'b1;
            eng_start_ff <= 1'b0;
            fg_done_ff   <= 1'b0;
            spare_ff     <= accc_pkg::CORE_C;
            slot_a_ff    <= accc_pkg::CORE_A;
            slot_b_ff    <= accc_pkg::CORE_B;
        end else begin
            eng_start_ff <= 1'b0;
            case (state_ff)
                ACCC_ST_IDLE: begin
                    if (pwr_cal_ff || (trig_rise && !cfg_ff[accc_pkg::CFG_BG])) begin
                        pwr_cal_ff   <= 1'b0;
                        fg_done_ff   <= 1'b0;
                        eng_start_ff <= 1'b1;
                        state_ff     <= ACCC_ST_FG_RUN;
                    end else if (cfg_ff[accc_pkg::CFG_BG] && trig_sel) begin
                        eng_start_ff <= 1'b1;
                        state_ff     <= ACCC_ST_BG_CAL;
                    end
                end
                ACCC_ST_FG_RUN: begin
                    if (eng_done) begin
                        fg_done_ff <= 1'b1;
                        state_ff   <= ACCC_ST_IDLE;
                    end
                end
                ACCC_ST_BG_CAL: begin
                    if (eng_done) begin
                        state_ff <= ACCC_ST_BG_SWAP;
                    end
                end
                ACCC_ST_BG_SWAP: begin
                    // spare into slot A or B
                    if (slot_a_ff == accc_next_core(spare_ff)) begin
                        slot_a_ff <= spare_ff;
                    end else begin
                        slot_b_ff <= spare_ff;
                    end
                    spare_ff <= accc_next_core(spare_ff);
                    if (cfg_ff[accc_pkg::CFG_BG] && trig_sel) begin
                        eng_start_ff <= 1'b1;
                        state_ff     <= ACCC_ST_BG_CAL;
                    end else begin
                        state_ff <= ACCC_ST_IDLE;
                    end
                end
                default: state_ff <= ACCC_ST_IDLE;
            endcase
        end
    end

    // busy flag, one cycle behind state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_busy_ff <= 1'b0;
        end else begin
            cal_busy_ff <= pwr_cal_ff || state_ff != ACCC_ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_ff <= 6'h2A;
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            online_ff <= 3'h0;
        end else if (state_ff == ACCC_ST_FG_RUN || pwr_cal_ff) begin
            online_ff <= 3'h0;
        end else begin
            online_ff <= (3'h1 << slot_a_ff) | (3'h1 << slot_b_ff);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out0_ff <= accc_pkg::MID_CODE;
            out1_ff <= accc_pkg::MID_CODE;
        end else if (state_ff == ACCC_ST_FG_RUN || pwr_cal_ff) begin
            out0_ff <= accc_pkg::MID_CODE;
            out1_ff <= accc_pkg::MID_CODE;
        end else if (cfg_ff[accc_pkg::CFG_DUAL]) begin
            out0_ff <= input_a;
            out1_ff <= input_b;
        end else begin
            out0_ff <= cfg_ff[accc_pkg::CFG_INSEL] ? input_b : input_a;
            out1_ff <= cfg_ff[accc_pkg::CFG_INSEL] ? input_b : input_a;
        end
    end

    assign rdata       = rdata_ff;
    assign sample_out0 = out0_ff;
    assign sample_out1 = out1_ff;
    assign core_online = online_ff;
    assign bank_phase  = phase_ff;
    assign fg_done     = fg_done_ff;
    assign cal_busy    = cal_busy_ff;

    fg_midcode_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_FG_RUN |=> out0_ff == accc_pkg::MID_CODE)
        else $error("output not mid-code in foreground");
    fg_offline_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_FG_RUN |=> online_ff == 3'h0)
        else $error("cores online during foreground");
    bg_online_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_BG_CAL |=> $countones(online_ff) == 2)
        else $error("background lost an active core");
    phase_opp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        phase_ff[0] != phase_ff[1] && phase_ff[2] != phase_ff[3]
        && phase_ff[4] != phase_ff[5])
        else $error("bank phases not opposite");
    dual_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_IDLE && !pwr_cal_ff && cfg_ff[accc_pkg::CFG_DUAL]
        && $stable(state_ff) |=> out1_ff == $past(input_b))
        else $error("channel B not routed");
    swap_rot_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_BG_SWAP |=> spare_ff != $past(spare_ff)
        && slot_a_ff != slot_b_ff)
        else $error("spare rotation failed");
    pwr_cal_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(pwr_cal_ff) |-> state_ff == ACCC_ST_FG_RUN)
        else $error("power-up calibration missing");
    done_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_FG_RUN && eng_done |=> fg_done_ff)
        else $error("done flag not set");
    trig_src_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_IDLE && !pwr_cal_ff && !cfg_ff[accc_pkg::CFG_BG]
        && cfg_ff[accc_pkg::CFG_SRCSEL] && cal_trigger_pin && !trig_d_ff
        |=> state_ff == ACCC_ST_FG_RUN)
        else $error("pin trigger did not start calibration");
    bg_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_BG_CAL && cfg_ff[accc_pkg::CFG_DUAL]
        |=> out0_ff == $past(input_a))
        else $error("background paused the output");
    single_route_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_IDLE && !pwr_cal_ff && !cfg_ff[accc_pkg::CFG_DUAL]
        |=> out0_ff == out1_ff)
        else $error("single channel outputs differ");
    swap_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_BG_SWAP
        |=> slot_a_ff == $past(spare_ff) || slot_b_ff == $past(spare_ff))
        else $error("spare not swapped in");
    busy_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state_ff == ACCC_ST_FG_RUN |=> cal_busy_ff)
        else $error("busy flag low during calibration");
    trim_wr_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_en && addr == accc_pkg::REG_TRIM0 |=> trim_ff[0] == $past(wdata))
        else $error("trim write lost");
endmodule

// ==== accc_sysctl_model.sv ====
`timescale 1ns/1ns
// Far-side controller: raises the trigger pin for a few cycles on request, once fg_done is set
module accc_sysctl_model #(
    parameter int HOLD = 3
) (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic fire,
    input  wire logic fg_done,
    output logic      cal_trigger_pin
);
    int   cnt_ff;
    logic pin_ff;

    assign cal_trigger_pin = pin_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 0;
            pin_ff <= 1'b0;
        end else if (fire && fg_done && cnt_ff == 0) begin
            cnt_ff <= HOLD;
            pin_ff <= 1'b1;
        end else if (cnt_ff > 1) begin
            cnt_ff <= cnt_ff - 1;
        end else if (cnt_ff == 1) begin
            cnt_ff <= 0;
            pin_ff <= 1'b0;
        end
    end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    localparam int          STEP = 4;
    localparam logic [31:0] TRIMS = 32'h44332211;
    logic        ref_clk, arst_n, wr_en, rd_en, fire, fg_done, cal_busy, pin;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, rv;
    logic [11:0] input_a, input_b, sample_out0, sample_out1;
    logic [2:0]  core_online, prev_on;
    logic [5:0]  bank_phase;
    int          miscompares, n_checks, swaps, ncyc;

    accc_top #(.STEP_CYCLES(STEP), .TRIM_DEFAULTS(TRIMS)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .cal_trigger_pin(pin),
        .input_a(input_a), .input_b(input_b), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_out0(sample_out0),
        .sample_out1(sample_out1), .core_online(core_online),
        .bank_phase(bank_phase), .fg_done(fg_done), .cal_busy(cal_busy));

    accc_sysctl_model u_ctl (
        .ref_clk(ref_clk), .arst_n(arst_n), .fire(fire), .fg_done(fg_done),
        .cal_trigger_pin(pin));

    task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 rv = rdata;
    endtask

    // Bounded wait for completion; ncyc counts the cycles waited until fg_done is seen
    task automatic wait_done();
        ncyc = 0;
        while (fg_done !== 1'b1 && ncyc < 300) begin
            @(posedge ref_clk);
            #1;
            ncyc++;
        end
        chk("fg_done", 12'h1, {11'h0, fg_done});
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Whole run is about 560 cycles
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    initial begin
        arst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; fire = 1'b0;
        addr = 4'h0; wdata = 8'h00; input_a = 12'h123; input_b = 12'h456;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("sample_out0", accc_pkg::MID_CODE, sample_out0);
        chk("core_online", 12'h0, {9'h0, core_online});
        wait_done();
        chk("fg span", 12'h1, {11'h0, ncyc >= 6 * STEP - 3 && ncyc <= 6 * STEP + 3});
        rd(accc_pkg::REG_STATUS);
        chk("status", 12'h001, {4'h0, rv});
        chk("busy idle", 12'h0, {11'h0, cal_busy});
        rd(accc_pkg::REG_CFG);
        chk("cfg", {4'h0, accc_pkg::CFG_RESET}, {4'h0, rv});
        for (int i = 0; i < accc_pkg::NUM_TRIM; i++) begin
            rd(accc_pkg::REG_TRIM0 + 4'(i));
            chk("trim default", {4'h0, TRIMS[8*i+:8]}, {4'h0, rv});
            wr(accc_pkg::REG_TRIM0 + 4'(i), 8'hA0 + 8'(i));
            rd(accc_pkg::REG_TRIM0 + 4'(i));
            chk("trim custom", 12'h0A0 + 12'(i), {4'h0, rv});
        end
        rd(4'hF);
        chk("unmapped", 12'h0, {4'h0, rv});
        repeat (4) @(posedge ref_clk);
        #1 chk("dual a", input_a, sample_out0);
        chk("dual b", input_b, sample_out1);
        chk("online", 12'h3, {9'h0, core_online});
        for (int c = 0; c < 3; c++)
            chk("phase pair", 12'h1, {11'h0, bank_phase[2*c] ^ bank_phase[2*c+1]});
        rv = {2'b00, bank_phase};
        @(posedge ref_clk);
        #1 chk("phase toggles", 12'h1, {11'h0, rv[0] ^ bank_phase[0]});
        for (int s = 0; s < 2; s++) begin
            wr(accc_pkg::REG_CFG, s ? 8'h20 : 8'h00);
            repeat (4) @(posedge ref_clk);
            #1 chk("single 0", s ? input_b : input_a, sample_out0);
            chk("single 1", s ? input_b : input_a, sample_out1);
        end
        // Pin pulse must be ignored while software source is selected
        wr(accc_pkg::REG_CFG, 8'h10);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 chk("pin ignored", 12'h1, {11'h0, fg_done});
        wr(accc_pkg::REG_CFG, 8'h12);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk("pin run", 12'h0, {11'h0, fg_done});
        chk("pin mid", accc_pkg::MID_CODE, sample_out1);
        chk("busy run", 12'h1, {11'h0, cal_busy});
        wait_done();
        wr(accc_pkg::REG_CFG, 8'h10);
        wr(accc_pkg::REG_TRIG, 8'h01);
        wr(accc_pkg::REG_TRIG, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk("soft run", 12'h0, {11'h0, fg_done});
        wait_done();
        wr(accc_pkg::REG_CFG, 8'h11);
        wr(accc_pkg::REG_TRIG, 8'h01);
        swaps = 0;
        prev_on = core_online;
        rv = 8'h00;
        repeat (400) begin
            @(posedge ref_clk);
            input_b <= input_b + 12'h011;
            #1 if (core_online !== prev_on) swaps++;
            prev_on = core_online;
            rv[0] = rv[0] | core_online[2];
            chk("bg online", 12'h2, {9'h0, 3'($countones(core_online))});
            chk("bg out1", input_b - 12'h011, sample_out1);
        end
        chk("spare used", 12'h1, {11'h0, rv[0]});
        chk("rotation", 12'h1, {11'h0, swaps >= 3});
        print_verdict();
    end
endmodule
